// ==== pg_delay_timer.v ====
`timescale 1ns/100ps
`include "pmic_sleep_defs.vh"

module pg_delay_timer #(
	parameter [23:0] TICK_CYC = `PG_TICK_CYC
) (
	// clock and control
	input wire clk,
	input wire resetn,
	input wire ce,
	input wire clear,
	// all grouped rails in regulation, timer allowed
	input wire run,
	input wire [2:0] sel,
	// delayed power good
	output reg pg
);

	localparam [23:0] tick_last = TICK_CYC - 24'h000001;

	reg [23:0] pre_r;
	reg [5:0] ticks_r;
	wire [5:0] ticks_nxt;

	// ======================================================================
	// delay code to count of base ticks
	// delay table
	function [5:0] delay_mult;
		input [2:0] code;
		begin
			case (code)
				3'h0: delay_mult = `PG_MULT_0;
				3'h1: delay_mult = `PG_MULT_1;
				3'h2: delay_mult = `PG_MULT_2;
				3'h3: delay_mult = `PG_MULT_3;
				3'h4: delay_mult = `PG_MULT_4;
				3'h5: delay_mult = `PG_MULT_5;
				3'h6: delay_mult = `PG_MULT_6;
				default: delay_mult = `PG_MULT_7;
			endcase
		end
	endfunction

	assign ticks_nxt = ticks_r + 6'h01;

	// ======================================================================
	// count only while the rails hold; any dropout restarts the delay
	always @(posedge clk) begin
		if (!resetn) begin
			pre_r <= 24'h000000;
			ticks_r <= 6'h00;
			pg <= 1'b0;
		end else if (ce) begin
			if (clear || !run) begin
				pre_r <= 24'h000000;
				ticks_r <= 6'h00;
				pg <= 1'b0;
			end else if (!pg) begin
				if (pre_r == tick_last) begin
					pre_r <= 24'h000000;
					ticks_r <= ticks_nxt;
					// >= so a shorter code chosen mid-delay still ends it
					if (ticks_nxt >= delay_mult(sel))
						pg <= 1'b1;
				end else begin
					pre_r <= pre_r + 24'h000001;
				end
			end
		end
	end

endmodule // pg_delay_timer

// ==== pmic_rail_voltage_sleep_regs.v ====
`timescale 1ns/100ps
`include "pmic_sleep_defs.vh"

module pmic_rail_voltage_sleep_regs #(
	// factory defaults (plain values, set per device option)
	parameter [7:0] DEF_PG_DELAY = 8'h00,
	parameter [7:0] DEF_RAIL1_SLEEP = 8'h00,
	parameter [7:0] DEF_RAIL2_SLEEP = 8'h00,
	parameter [7:0] DEF_RAIL4_CODE = 8'h00,
	// sleep pin choice: 0 follows pin a, 1 follows pin b
	parameter RAIL1_PIN_B = 0,
	parameter RAIL2_PIN_B = 1,
	// step range: 0 fine, 1 coarse
	parameter RAIL1_COARSE = 0,
	parameter RAIL2_COARSE = 0,
	parameter RAIL4_COARSE = 1,
	// base tick of the power-good delay in clock cycles
	parameter [23:0] PG_TICK_CYC = `PG_TICK_CYC
) (
	// clock, reset, enable
	input wire REF_CLK,
	input wire RESETN,
	input wire CE,
	// register port from the serial engine
	input wire [7:0] REG_ADDR,
	input wire [7:0] REG_WDATA,
	input wire REG_WR,
	input wire REG_RD,
	output reg [7:0] REG_RDATA,
	output reg REG_ACK,
	// sleep pins
	input wire SLEEP_PIN_A,
	input wire SLEEP_PIN_B,
	// normal codes of rails 1 and 2 held elsewhere
	input wire [6:0] RAIL1_NORMAL_CODE,
	input wire [6:0] RAIL2_NORMAL_CODE,
	// output three configuration and status
	input wire RAILS_IN_REG,
	input wire OUT3_IS_PG,
	input wire OUT3_TERM_USE,
	input wire OUT3_HOST_LEVEL,
	output reg GENERAL_OUTPUT_THREE,
	output reg TERM_REG_EN,
	// emergency shutdown request
	output reg EMERG_SHUTDOWN,
	// regulation targets
	output reg [6:0] RAIL1_TARGET_CODE,
	output reg [6:0] RAIL2_TARGET_CODE,
	output reg [6:0] RAIL4_TARGET_CODE,
	output reg [4:0] RAIL1_STEP_MV,
	output reg [4:0] RAIL2_STEP_MV,
	output reg [4:0] RAIL4_STEP_MV,
	// rail 4 downward moves
	output reg RAIL4_SLEW_DOWN,
	output reg RAIL4_DECAY_DOWN
);

	// ======================================================================
	// register map held here
	// 0x43 output three delay: bits 2:0 selector, 7:3 read zero
	// 0x91 forced shutdown: bit 0 self clearing, 7:1 read zero
	// 0x92 rail 1 sleep: code 7:1, sleep enable 0
	// 0x93 rail 2 sleep: code 7:1, sleep enable 0
	// 0x94 rail 4 normal: code 7:1, decay select 0
	// rail 1 and 2 normal codes live outside this bank
	// reserved bits read zero and drop writes

	// ======================================================================
	// state
	reg [2:0] pg_delay_sel_r;
	reg [7:0] rail1_sleep_r;
	reg [7:0] rail2_sleep_r;
	reg [7:0] rail4_code_r;
	reg shdn_r;
	wire pg_delayed;
	wire delay_used;
	wire wr_shdn;
	wire wr_hit;
	wire rail1_asleep;
	wire rail2_asleep;
	reg [7:0] read_mux;
	wire wr_rail4;
	wire rail4_going_down;

	// ======================================================================
	// helpers
	function [4:0] step_mv;
		input coarse;
		begin
			step_mv = coarse ? `STEP_COARSE_MV : `STEP_FINE_MV;
		end
	endfunction

	// voltage code sits above the flag bit in every rail register
	function [6:0] code_field;
		input [7:0] rail_reg;
		begin
			code_field = rail_reg[`CODE_MSB:`CODE_LSB];
		end
	endfunction

	// sleep code only when enabled and the chosen pin is low
	function [6:0] pick_code;
		input [7:0] sleep_reg;
		input [6:0] normal;
		input pin_level;
		begin
			if (sleep_reg[`FLAG_BIT] && !pin_level)
				pick_code = code_field(sleep_reg);
			else
				pick_code = normal;
		end
	endfunction

	// ======================================================================
	// decode
	// no acknowledge
	assign wr_shdn = REG_WR && (REG_ADDR == `ADDR_FORCE_SHDN) &&
		REG_WDATA[`SHDN_BIT];
	assign wr_hit = REG_WR && !wr_shdn;
	// pin choice is a factory option, so no register bit can move it
	// fixed pin choice
	assign rail1_asleep = (RAIL1_PIN_B != 0) ? SLEEP_PIN_B : SLEEP_PIN_A;
	assign rail2_asleep = (RAIL2_PIN_B != 0) ? SLEEP_PIN_B : SLEEP_PIN_A;
	assign delay_used = OUT3_IS_PG || OUT3_TERM_USE;
	// only the code field decides; the decay flag rides along as the mode
	// downward move
	assign wr_rail4 = REG_WR && !shdn_r &&
		(REG_ADDR == `ADDR_RAIL4_CODE);
	assign rail4_going_down = wr_rail4 &&
		(code_field(REG_WDATA) < code_field(rail4_code_r));

	// ======================================================================
	// power-good delay for output three
	// delay then good
	pg_delay_timer #(
		.TICK_CYC(PG_TICK_CYC)
	) u_out3_timer (
		.clk(REF_CLK),
		.resetn(RESETN),
		.ce(CE),
		.clear(shdn_r),
		.run(RAILS_IN_REG && delay_used),
		.sel(pg_delay_sel_r),
		.pg(pg_delayed)
	);

	// ======================================================================
	// register file; shutdown reloads factory defaults one cycle later
	// the reload eats any strobe write in that cycle; the host gets no
	// acknowledge for the shutdown write and waits before using the bank
	always @(posedge REF_CLK) begin
		if (!RESETN) begin
			pg_delay_sel_r <= DEF_PG_DELAY[`DELAY_SEL_MSB:0];
			rail1_sleep_r <= DEF_RAIL1_SLEEP;
			rail2_sleep_r <= DEF_RAIL2_SLEEP;
			rail4_code_r <= DEF_RAIL4_CODE;
			shdn_r <= 1'b0;
		end else if (CE) begin
			if (shdn_r) begin
				pg_delay_sel_r <= DEF_PG_DELAY[`DELAY_SEL_MSB:0];
				rail1_sleep_r <= DEF_RAIL1_SLEEP;
				rail2_sleep_r <= DEF_RAIL2_SLEEP;
				rail4_code_r <= DEF_RAIL4_CODE;
				// a repeated shutdown write here wins over the clear
				// self clearing
				shdn_r <= wr_shdn;
			end else if (wr_shdn) begin
				shdn_r <= 1'b1;
			end else if (REG_WR) begin
				case (REG_ADDR)
					`ADDR_PG_OUT3_DELAY: begin
						pg_delay_sel_r <= REG_WDATA[`DELAY_SEL_MSB:0];
					end
					`ADDR_RAIL1_SLEEP: begin
						rail1_sleep_r <= REG_WDATA;
					end
					`ADDR_RAIL2_SLEEP: begin
						rail2_sleep_r <= REG_WDATA;
					end
					`ADDR_RAIL4_CODE: begin
						rail4_code_r <= REG_WDATA;
					end
					default: begin
						pg_delay_sel_r <= pg_delay_sel_r;
					end
				endcase
			end
		end
	end

	// ======================================================================
	// read data; unmapped offsets read zero
	// combinational here, the port only shows the registered copy
	always @* begin
		case (REG_ADDR)
			`ADDR_PG_OUT3_DELAY: read_mux = {5'h00, pg_delay_sel_r};
			`ADDR_FORCE_SHDN: read_mux = {7'h00, shdn_r};
			`ADDR_RAIL1_SLEEP: read_mux = rail1_sleep_r;
			`ADDR_RAIL2_SLEEP: read_mux = rail2_sleep_r;
			`ADDR_RAIL4_CODE: read_mux = rail4_code_r;
			default: read_mux = `READ_ZERO;
		endcase
	end

	// ======================================================================
	// bus answer: one cycle after the strobe; write wins over read
	// a read in the same cycle as a write is dropped, not queued
	always @(posedge REF_CLK) begin
		if (!RESETN) begin
			REG_RDATA <= 8'h00;
			REG_ACK <= 1'b0;
		end else if (CE) begin
			REG_ACK <= wr_hit || (REG_RD && !REG_WR);
			if (REG_RD && !REG_WR)
				REG_RDATA <= read_mux;
		end
	end

	// ======================================================================
	// shutdown and output three drive
	// termination follows delayed good when OUT3_TERM_USE is set; the host level never enables it
	always @(posedge REF_CLK) begin
		if (!RESETN) begin
			EMERG_SHUTDOWN <= 1'b0;
			GENERAL_OUTPUT_THREE <= 1'b0;
			TERM_REG_EN <= 1'b0;
		end else if (CE) begin
			EMERG_SHUTDOWN <= shdn_r;
			GENERAL_OUTPUT_THREE <= OUT3_IS_PG ? pg_delayed :
				OUT3_HOST_LEVEL;
			TERM_REG_EN <= OUT3_TERM_USE && pg_delayed;
		end
	end

	// ======================================================================
	// regulation targets, refreshed every enabled cycle
	// step sizes are factory fixed but still leave a flop like the codes
	always @(posedge REF_CLK) begin
		if (!RESETN) begin
			RAIL1_TARGET_CODE <= 7'h00;
			RAIL2_TARGET_CODE <= 7'h00;
			RAIL4_TARGET_CODE <= 7'h00;
			RAIL1_STEP_MV <= 5'h00;
			RAIL2_STEP_MV <= 5'h00;
			RAIL4_STEP_MV <= 5'h00;
		end else if (CE) begin
			RAIL1_TARGET_CODE <= pick_code(rail1_sleep_r, RAIL1_NORMAL_CODE,
				rail1_asleep);
			RAIL2_TARGET_CODE <= pick_code(rail2_sleep_r, RAIL2_NORMAL_CODE,
				rail2_asleep);
			RAIL4_TARGET_CODE <= code_field(rail4_code_r);
			RAIL1_STEP_MV <= step_mv(RAIL1_COARSE != 0);
			RAIL2_STEP_MV <= step_mv(RAIL2_COARSE != 0);
			RAIL4_STEP_MV <= step_mv(RAIL4_COARSE != 0);
		end
	end

	// ======================================================================
	// rail 4 downward move: pulse tells the converter how to get there
	always @(posedge REF_CLK) begin
		if (!RESETN) begin
			RAIL4_SLEW_DOWN <= 1'b0;
			RAIL4_DECAY_DOWN <= 1'b0;
		end else if (CE) begin
			RAIL4_SLEW_DOWN <= 1'b0;
			RAIL4_DECAY_DOWN <= 1'b0;
			if (rail4_going_down) begin
				RAIL4_SLEW_DOWN <= !REG_WDATA[`FLAG_BIT];
				RAIL4_DECAY_DOWN <= REG_WDATA[`FLAG_BIT];
			end
		end
	end

endmodule // pmic_rail_voltage_sleep_regs

// ==== pmic_regs_assertions.sv ====
`timescale 1ns/100ps
`include "pmic_sleep_defs.vh"
// ==========================================================================
// port checker
module pmic_regs_checker (
	// clock and reset
	input wire REF_CLK,
	input wire RESETN,
	input wire CE,
	// register port
	input wire [7:0] REG_ADDR,
	input wire [7:0] REG_WDATA,
	input wire REG_WR,
	input wire REG_RD,
	input wire [7:0] REG_RDATA,
	input wire REG_ACK,
	// output three
	input wire RAILS_IN_REG,
	input wire OUT3_IS_PG,
	input wire OUT3_HOST_LEVEL,
	input wire GENERAL_OUTPUT_THREE,
	// shutdown and rails
	input wire EMERG_SHUTDOWN,
	input wire [4:0] RAIL1_STEP_MV,
	input wire [4:0] RAIL4_STEP_MV,
	input wire RAIL4_SLEW_DOWN,
	input wire RAIL4_DECAY_DOWN
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RESETN);

	// accepted strobes
	wire wr_go = CE && REG_WR;
	wire rd_go = CE && REG_RD && !REG_WR;
	wire shdn_go = wr_go && REG_ADDR == 8'h91 && REG_WDATA[0];
	wire r4_go = wr_go && REG_ADDR == 8'h94;
	wire unmapped = !(REG_ADDR inside {8'h43, 8'h91, 8'h92, 8'h93, 8'h94});

	sequence s_shdn;
		shdn_go ##1 CE;
	endsequence
	sequence s_no_good;
		(CE && OUT3_IS_PG && !RAILS_IN_REG)[*2];
	endsequence

	property p_wr_ack;
		wr_go && !shdn_go |=> REG_ACK;
	endproperty
	a_wr_ack: assert property (p_wr_ack)
		else $error("write not answered");
	property p_shdn;
		s_shdn |-> !REG_ACK ##1 EMERG_SHUTDOWN;
	endproperty
	a_shdn: assert property (p_shdn)
		else $error("shutdown write answered or no shutdown");
	property p_emerg_cause;
		EMERG_SHUTDOWN |-> $past(shdn_go, 2);
	endproperty
	a_emerg_cause: assert property (p_emerg_cause)
		else $error("shutdown without request");
	property p_rd_shdn;
		rd_go && REG_ADDR == 8'h91 |=> REG_RDATA[7:1] == 7'h00;
	endproperty
	a_rd_shdn: assert property (p_rd_shdn)
		else $error("reserved shutdown bits not zero");
	property p_unmapped;
		rd_go && unmapped |=> REG_ACK && REG_RDATA == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");
	property p_slew;
		RAIL4_SLEW_DOWN |-> $past(r4_go && !REG_WDATA[0])
			|| $past(r4_go && !REG_WDATA[0], 2);
	endproperty
	a_slew: assert property (p_slew)
		else $error("slew without active write");
	property p_decay;
		RAIL4_DECAY_DOWN |-> $past(r4_go && REG_WDATA[0])
			|| $past(r4_go && REG_WDATA[0], 2);
	endproperty
	a_decay: assert property (p_decay)
		else $error("decay without passive write");
	property p_host;
		CE && !OUT3_IS_PG |=> GENERAL_OUTPUT_THREE == $past(OUT3_HOST_LEVEL);
	endproperty
	a_host: assert property (p_host)
		else $error("output three ignores host level");
	property p_pg_low;
		s_no_good |=> !GENERAL_OUTPUT_THREE;
	endproperty
	a_pg_low: assert property (p_pg_low)
		else $error("power good without regulation");
	property p_step;
		$past(RESETN) && $past(RESETN, 2) && $past(RESETN, 3) |->
			RAIL4_STEP_MV == `STEP_COARSE_MV && RAIL1_STEP_MV == `STEP_FINE_MV;
	endproperty
	a_step: assert property (p_step)
		else $error("step size wrong");
endmodule // pmic_regs_checker

bind pmic_rail_voltage_sleep_regs pmic_regs_checker i_chk (
	.REF_CLK(REF_CLK), .RESETN(RESETN), .CE(CE), .REG_ADDR(REG_ADDR),
	.REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
	.REG_RDATA(REG_RDATA), .REG_ACK(REG_ACK), .RAILS_IN_REG(RAILS_IN_REG),
	.OUT3_IS_PG(OUT3_IS_PG), .OUT3_HOST_LEVEL(OUT3_HOST_LEVEL),
	.GENERAL_OUTPUT_THREE(GENERAL_OUTPUT_THREE),
	.EMERG_SHUTDOWN(EMERG_SHUTDOWN), .RAIL1_STEP_MV(RAIL1_STEP_MV),
	.RAIL4_STEP_MV(RAIL4_STEP_MV), .RAIL4_SLEW_DOWN(RAIL4_SLEW_DOWN),
	.RAIL4_DECAY_DOWN(RAIL4_DECAY_DOWN));

// ==== pmic_sleep_defs.vh ====
`ifndef PMIC_SLEEP_DEFS_VH
`define PMIC_SLEEP_DEFS_VH

// ==========================================================================
// register offsets
`define ADDR_PG_OUT3_DELAY 8'h43
`define ADDR_FORCE_SHDN 8'h91
`define ADDR_RAIL1_SLEEP 8'h92
`define ADDR_RAIL2_SLEEP 8'h93
`define ADDR_RAIL4_CODE 8'h94

// ==========================================================================
// field positions
`define SHDN_BIT 0
`define CODE_MSB 7
`define CODE_LSB 1
`define FLAG_BIT 0
`define DELAY_SEL_MSB 2

// ==========================================================================
// reset values and reserved masks
`define FORCE_SHDN_RST 8'h00
`define PG_DELAY_MASK 8'h07
`define READ_ZERO 8'h00

// ==========================================================================
// timing: delay table is built from a 2.5 ms base tick
`define CLK_KHZ 10000
`define PG_TICK_US 2500
// 2.5 ms at 10 MHz, sized to the 24-bit prescaler
`define PG_TICK_CYC 24'h0061a8
// tick multiples for 2.5, 5, 10, 15, 20, 50, 75, 100 ms
`define PG_MULT_0 6'h01
`define PG_MULT_1 6'h02
`define PG_MULT_2 6'h04
`define PG_MULT_3 6'h06
`define PG_MULT_4 6'h08
`define PG_MULT_5 6'h14
`define PG_MULT_6 6'h1e
`define PG_MULT_7 6'h28

// ==========================================================================
// code step sizes in millivolts
`define STEP_FINE_MV 5'h0a
`define STEP_COARSE_MV 5'h19

`endif

// ==== reg_host.sv ====
`timescale 1ns/100ps
// ==========================================================================
// register host standing for the serial engine
module reg_host (
	// clock
	input wire logic clk,
	// strobe port towards the device
	output logic [7:0] addr,
	output logic [7:0] wdata,
	output logic wr,
	output logic rd,
	input wire logic [7:0] rdata,
	input wire logic ack
);
	// idle port before the first access
	initial begin
		addr = 8'h00;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
	end

	// one-cycle strobe, answer taken a cycle later
	// silent shutdown accepted
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [7:0] d, output logic k, output logic [7:0] q);
		@(negedge clk);
		wr = w;
		rd = !w;
		addr = a;
		wdata = d;
		@(negedge clk);
		wr = 1'b0;
		rd = 1'b0;
		// released lines flip so stale values cannot pass as good
		addr = ~a;
		wdata = ~d;
		k = ack;
		q = rdata;
	endtask
endmodule // reg_host

// ==== tb.sv ====
`timescale 1ns/100ps
`define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin n_fail++; \
	$display("mismatch %s exp %h got %h", nm, e, s); end end
module tb;
	// ======================================================================
	// signals
	localparam int TICK = 4;
	logic ref_clk = 1'b0, resetn = 1'b0, ce = 1'b1;
	logic pin_a = 1'b1, pin_b = 1'b1;
	logic [6:0] nrm1 = 7'h15, nrm2 = 7'h2a;
	logic in_reg = 1'b0, is_pg = 1'b0, term = 1'b0, host_lvl = 1'b0;
	logic [7:0] addr, wdata, rdata, q, a, d;
	logic wr, rd, ack, out3, term_en, emerg, slew, decay, k;
	logic [6:0] t1, t2, t4;
	logic [4:0] s1, s2, s4;
	int n_fail = 0, checked = 0, cyc = 0, seed = 35760, n;
	int n_slew = 0, n_decay = 0, n_emerg = 0, ns, nd;
	logic [7:0] regs [5] = '{8'h43, 8'h91, 8'h92, 8'h93, 8'h94};

	reg_host i_host (.clk(ref_clk), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .ack(ack));
	// short tick keeps the longest delay at 160 cycles
	pmic_rail_voltage_sleep_regs #(.PG_TICK_CYC(24'd4)) i_dut (
		.REF_CLK(ref_clk), .RESETN(resetn), .CE(ce), .REG_ADDR(addr),
		.REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
		.REG_ACK(ack), .SLEEP_PIN_A(pin_a), .SLEEP_PIN_B(pin_b),
		.RAIL1_NORMAL_CODE(nrm1), .RAIL2_NORMAL_CODE(nrm2),
		.RAILS_IN_REG(in_reg), .OUT3_IS_PG(is_pg), .OUT3_TERM_USE(term),
		.OUT3_HOST_LEVEL(host_lvl), .GENERAL_OUTPUT_THREE(out3),
		.TERM_REG_EN(term_en), .EMERG_SHUTDOWN(emerg),
		.RAIL1_TARGET_CODE(t1), .RAIL2_TARGET_CODE(t2),
		.RAIL4_TARGET_CODE(t4), .RAIL1_STEP_MV(s1), .RAIL2_STEP_MV(s2),
		.RAIL4_STEP_MV(s4), .RAIL4_SLEW_DOWN(slew), .RAIL4_DECAY_DOWN(decay));

	// 100 ns clock
	initial forever #50 ref_clk = ~ref_clk;

	// pulse counters and hang limit
	always @(posedge ref_clk) begin
		cyc++;
		n_slew += slew;
		n_decay += decay;
		n_emerg += emerg;
		if (cyc == 5000) begin
			n_fail++;
			complete_run();
		end
	end

	// ======================================================================
	// expectations
	function automatic int pg_mult(input logic [2:0] c);
		int tenth_ms [8] = '{25, 50, 100, 150, 200, 500, 750, 1000};
		return tenth_ms[c] / 25;
	endfunction
	function automatic logic [6:0] tgt(input logic [7:0] r,
		input logic [6:0] nrm, input logic pin);
		return (r[0] && !pin) ? r[7:1] : nrm;
	endfunction

	// ======================================================================
	// access tasks
	task automatic wreg(input logic [7:0] ad, input logic [7:0] v,
		input logic ek);
		i_host.xfer(1'b1, ad, v, k, q);
		`CHK("write ack", ek, k)
	endtask
	task automatic rchk(input logic [7:0] ad, input logic [7:0] e);
		i_host.xfer(1'b0, ad, 8'h00, k, q);
		`CHK("read ack", 1'b1, k)
		`CHK("read data", e, q)
	endtask
	task automatic chk_tg(input logic [7:0] r1, input logic [7:0] r2);
		repeat (4) @(negedge ref_clk);
		`CHK("rail1 target", tgt(r1, nrm1, pin_a), t1)
		`CHK("rail2 target", tgt(r2, nrm2, pin_b), t2)
	endtask
	task complete_run();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ======================================================================
	// main sequence
	initial begin
		repeat (2) @(negedge ref_clk);
		resetn = 1'b1;
		repeat (3) @(negedge ref_clk);
		`CHK("rail1 step", 5'd10, s1)
		`CHK("rail4 step", 5'd25, s4)
		`CHK("rail2 step", 5'd10, s2)
		foreach (regs[i]) rchk(regs[i], 8'h00);
		// random traffic; shutdown bit kept clear to stay alive
		repeat (20) begin
			a = regs[$unsigned($random(seed)) % 5];
			d = $random(seed);
			if (a == 8'h91) d[0] = 1'b0;
			wreg(a, d, 1'b1);
			rchk(a, a == 8'h43 ? d & 8'h07 : a == 8'h91 ? 8'h00 : d);
		end
		wreg(8'h50, 8'hff, 1'b1);
		rchk(8'h50, 8'h00);
		wreg(8'h92, 8'h0b, 1'b1);
		wreg(8'h93, 8'h63, 1'b1);
		// frozen port must drop the write; let the last ack clear first
		@(negedge ref_clk);
		ce = 1'b0;
		i_host.xfer(1'b1, 8'h92, 8'h5a, k, q);
		ce = 1'b1;
		`CHK("frozen ack", 1'b0, k)
		rchk(8'h92, 8'h0b);
		for (int i = 0; i < 4; i++) begin
			{pin_a, pin_b} = i[1:0];
			chk_tg(8'h0b, 8'h63);
		end
		pin_a = 1'b0;
		wreg(8'h92, 8'h0a, 1'b1);
		chk_tg(8'h0a, 8'h63);
		wreg(8'h94, 8'h80, 1'b1);
		// the set-up write may pulse too; count it before the baseline
		@(negedge ref_clk);
		ns = n_slew;
		nd = n_decay;
		wreg(8'h94, 8'h20, 1'b1);
		wreg(8'h94, 8'h11, 1'b1);
		wreg(8'h94, 8'h7e, 1'b1);
		repeat (3) @(negedge ref_clk);
		`CHK("slews", 1, n_slew - ns)
		`CHK("decays", 1, n_decay - nd)
		`CHK("rail4 target", 7'h3f, t4)
		// every delay code, timed from regulation
		is_pg = 1'b1;
		for (int c = 0; c < 8; c++) begin
			in_reg = 1'b0;
			wreg(8'h43, c[7:0], 1'b1);
			repeat (3) @(negedge ref_clk);
			`CHK("pg early", 1'b0, out3)
			in_reg = 1'b1;
			n = 0;
			while (out3 !== 1'b1 && n < 400) begin
				@(negedge ref_clk);
				n++;
			end
			`CHK("pg delay", 1'b1, (n - pg_mult(c) * TICK) inside {[1:3]})
		end
		is_pg = 1'b0;
		host_lvl = 1'b1;
		repeat (2) @(negedge ref_clk);
		`CHK("host level", 1'b1, out3)
		`CHK("term off", 1'b0, term_en)
		host_lvl = 1'b0;
		in_reg = 1'b0;
		wreg(8'h43, 8'h00, 1'b1);
		term = 1'b1;
		in_reg = 1'b1;
		repeat (10) @(negedge ref_clk);
		`CHK("term on", 1'b1, term_en)
		// shutdown must restore defaults
		wreg(8'h94, 8'h55, 1'b1);
		ns = n_emerg;
		wreg(8'h91, 8'h01, 1'b0);
		repeat (3) @(negedge ref_clk);
		`CHK("shutdowns", 1, n_emerg - ns)
		rchk(8'h94, 8'h00);
		rchk(8'h91, 8'h00);
		complete_run();
	end
endmodule // tb
